// ===== io_space_access_decode.sv
// I/O space access decoder with a bank of 64 byte registers.
// Assumes the CPU core holds op, address and data for the request cycle only.
//
// Summary of operation
// - Bit set and bit clear modify single bits of registers 0x00 to 0x1F.
// - Skip-if-bit-set and skip-if-bit-clear test one bit of the lower 32 registers.
// - I/O input and output address 0x00 to 0x3F and move one byte.
// - Data-space loads and stores reach I/O register n at address n plus 0x20.
// - Write-one-to-clear flags clear on one; writing zero leaves them unchanged.
// - Bit set and clear write the whole register back, clearing flags read as one other than the bit being cleared.
`timescale 1ns/1ps
`default_nettype none

module io_space_access_decode
  import io_space_pkg::*;
#(
  parameter logic [63:0] RESERVED_ADDR = 64'h0000_0000_0000_0000, // Unimplemented locations
  parameter logic [7:0]  W1C_MASK      = 8'h80,                    // Flag bits cleared by one
  parameter logic [63:0] W1C_ADDR      = 64'h0000_0000_0000_0001  // Locations holding flags
)
(
  input  wire logic                               clock,       // 50 MHz CPU clock
  input  wire logic                               nrst,        // Async reset, active low
  input  wire logic                               req,         // Operation valid this cycle
  input  wire io_space_pkg::io_op_e               op,          // Operation kind
  input  wire logic [io_space_pkg::IO_ADDR_W-1:0] io_addr,     // I/O address for in/out/bit ops
  input  wire logic [io_space_pkg::DATA_ADDR_W-1:0] data_addr, // Data-space address for load/store
  input  wire logic [2:0]                         bit_sel,     // Bit number for bit ops
  input  wire logic [7:0]                         wdata,       // Write data
  input  wire logic [63:0]                        flag_set,    // Hardware flag set strobes, per location
  output logic [7:0]                              rdata,       // Read data, registered
  output logic                                    rvalid,      // Read data valid pulse
  output logic                                    skip,        // Skip next instruction pulse
  output logic                                    hit,         // Request decoded to I/O space
  output logic [63:0][7:0]                        reg_q        // Register contents to peripherals
);

  // ****************************************
  // Address decode
  // ****************************************
  logic [5:0]  sel_addr;
  logic        sel_ok;
  logic        is_bit_op;
  logic        is_skip_op;
  logic        is_store_op;
  logic        is_load_op;
  logic        is_write;
  logic        is_read;
  logic        is_skip;
  logic [15:0] data_rel;

  // Operation classes, independent of the address
  always_comb
  begin
    is_bit_op   = (op == OP_BIT_SET) || (op == OP_BIT_CLEAR);
    is_skip_op  = (op == OP_SKIP_IF_SET) || (op == OP_SKIP_IF_CLEAR);
    is_store_op = (op == OP_IO_OUT) || (op == OP_DATA_STORE);
    is_load_op  = (op == OP_IO_IN) || (op == OP_DATA_LOAD);
  end

  // Out-of-range requests give no hit and leave every register alone
  always_comb
  begin
    data_rel = data_addr - IO_DATA_OFFSET;
    sel_addr = io_addr;
    sel_ok   = 1'b0;
    unique case (op)
      OP_IO_IN, OP_IO_OUT:
      begin
        sel_ok = (io_addr >= IO_FIRST) && (io_addr <= IO_LAST);
      end
      OP_BIT_SET, OP_BIT_CLEAR, OP_SKIP_IF_SET, OP_SKIP_IF_CLEAR:
      begin
        sel_ok = (io_addr <= IO_BIT_LAST);
      end
      OP_DATA_LOAD, OP_DATA_STORE:
      begin
        sel_addr = data_rel[5:0];
        sel_ok   = (data_addr >= IO_DATA_OFFSET) && (data_addr <= IO_DATA_LAST);
      end
    endcase
    hit      = req && sel_ok;
    is_write = hit && (is_store_op || is_bit_op) && !RESERVED_ADDR[sel_addr];
    is_read  = hit && is_load_op;
    is_skip  = hit && is_skip_op;
  end

  // ****************************************
  // Register bank
  // ****************************************
  logic [63:0][7:0] regs;
  logic [63:0][7:0] next_regs;
  logic [7:0]       cur;
  logic [7:0]       bit_mask;
  logic [7:0]       wr_val;

  // Bit ops write the whole byte back, so W1C flags read as one clear, except the bit a bit clear targets
  always_comb
  begin
    cur      = regs[sel_addr];
    bit_mask = 8'h01 << bit_sel;
    wr_val   = wdata;
    if (op == OP_BIT_SET)
    begin
      wr_val = cur | bit_mask;
    end
    else if (op == OP_BIT_CLEAR)
    begin
      wr_val = cur & ~bit_mask;
    end
  end

  // One write enable and one W1C merge per location
  genvar g;
  generate
    for (g = 0; g < 64; g++)
    begin : g_loc
      logic loc_we;

      assign loc_we = is_write && (sel_addr == 6'(g));

      always_comb
      begin
        next_regs[g] = regs[g];
        if (loc_we)
        begin
          if (W1C_ADDR[g])
          begin
            next_regs[g] = (regs[g] & W1C_MASK & ~wr_val) |
                           (wr_val & ~W1C_MASK);
          end
          else
          begin
            next_regs[g] = wr_val;
          end
        end
        if (W1C_ADDR[g] && flag_set[g])
        begin
          next_regs[g] = next_regs[g] | W1C_MASK;                  // Set wins over clear
        end
      end

      always_ff @(posedge clock or negedge nrst)
      begin
        if (!nrst)
        begin
          regs[g] <= REG_RESET;
        end
        else
        begin
          regs[g] <= next_regs[g];
        end
      end
    end
  endgenerate

  assign reg_q = regs;

  // ****************************************
  // Read answer
  // ****************************************
  logic [7:0] next_rdata;
  logic       next_rvalid;

  always_comb
  begin
    next_rdata  = rdata;
    next_rvalid = is_read;
    if (is_read)
    begin
      next_rdata = cur;
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata  <= REG_RESET;
      rvalid <= 1'b0;
    end
    else
    begin
      rdata  <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  // ****************************************
  // Skip answer
  // ****************************************
  logic next_skip;

  // Skip-if-clear tests the inverse of the selected bit
  always_comb
  begin
    next_skip = 1'b0;
    if (is_skip && (op == OP_SKIP_IF_SET))
    begin
      next_skip = cur[bit_sel];
    end
    else if (is_skip)
    begin
      next_skip = !cur[bit_sel];
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      skip <= 1'b0;
    end
    else
    begin
      skip <= next_skip;
    end
  end

endmodule : io_space_access_decode

`default_nettype wire

// ===== io_space_pkg.sv
// Package for the I/O space access decoder: address limits, op codes, widths.
// Assumes a single-clock CPU core that issues one I/O operation per request.
`default_nettype none

package io_space_pkg;

  localparam int unsigned IO_ADDR_W      = 6;
  localparam int unsigned DATA_ADDR_W    = 16;
  localparam logic [5:0]  IO_FIRST       = 6'h00;
  localparam logic [5:0]  IO_LAST        = 6'h3f;
  localparam logic [5:0]  IO_BIT_LAST    = 6'h1f;
  localparam logic [15:0] IO_DATA_OFFSET = 16'h0020;
  localparam logic [15:0] IO_DATA_LAST   = 16'h005f;
  localparam logic [7:0]  REG_RESET      = 8'h00;

  typedef enum logic [2:0]
  {
    OP_IO_IN         = 3'b000,
    OP_IO_OUT        = 3'b001,
    OP_BIT_SET       = 3'b010,
    OP_BIT_CLEAR     = 3'b011,
    OP_SKIP_IF_SET   = 3'b100,
    OP_SKIP_IF_CLEAR = 3'b101,
    OP_DATA_LOAD     = 3'b110,
    OP_DATA_STORE    = 3'b111
  } io_op_e;

endpackage : io_space_pkg

`default_nettype wire

// ===== io_cpu_model.sv
// CPU core model: issues one I/O request per call.
// Assumes the bench calls go or idle once per cycle.
`timescale 1ns/1ps
`default_nettype none
module io_cpu_model
  import io_space_pkg::*;
(
  input  wire logic           clock,     // CPU clock
  output logic                req,       // Request
  output io_space_pkg::io_op_e op,       // Operation
  output logic [5:0]          io_addr,   // I/O address
  output logic [15:0]         data_addr, // Data address
  output logic [2:0]          bit_sel,   // Bit number
  output logic [7:0]          wdata      // Write data
);
  initial
  begin
    req = 1'b0;
    op = OP_IO_IN;
    {io_addr, data_addr, bit_sel, wdata} = '0;
  end
  task go(input io_op_e o, input logic [15:0] a, input logic [2:0] b, input logic [7:0] d); // Any address, mapped or not
    @(posedge clock);
    #1;
    req = 1'b1;
    op = o;
    io_addr = a[5:0];
    data_addr = a;
    bit_sel = b;
    wdata = d;
  endtask : go
  task idle();
    @(posedge clock);
    #1;
    req = 1'b0;
    {io_addr, data_addr, wdata} = ~{io_addr, data_addr, wdata};
  endtask : idle
endmodule : io_cpu_model
`default_nettype wire

// ===== io_space_access_decode_properties.sv
// Checker on the decoder ports.
// Assumes default parameters: one flag, bit 7 of location 0.
`timescale 1ns/1ps
`default_nettype none
module io_space_checker
  import io_space_pkg::*;
(
  input wire logic                  clock,     // CPU clock
  input wire logic                  nrst,      // Async reset, active low
  input wire logic                  req,       // Request valid
  input wire logic                  rvalid,    // Read data valid
  input wire logic                  skip,      // Skip pulse
  input wire logic                  hit,       // Decoded hit
  input wire io_space_pkg::io_op_e  op,        // Operation
  input wire logic [5:0]            io_addr,   // I/O address
  input wire logic [15:0]           data_addr, // Data address
  input wire logic [2:0]            bit_sel,   // Bit number
  input wire logic [7:0]            wdata,     // Write data
  input wire logic [7:0]            rdata,     // Read data
  input wire logic [63:0]           flag_set,  // Flag set strobes
  input wire logic [63:0][7:0]      reg_q      // Register contents
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_io_read: assert property (req && op == OP_IO_IN && hit
    |=> rvalid && rdata == $past(reg_q[io_addr])) else $error("read");
  a_bit_range: assert property (req && op[2:1] == 2'b01 && io_addr > IO_BIT_LAST |-> !hit) else $error("range");
  a_bit_set: assert property (req && op == OP_BIT_SET && hit && io_addr != 6'h00
    |=> reg_q[$past(io_addr)][$past(bit_sel)]) else $error("set");
  a_skip_test: assert property (req && op[2:1] == 2'b10 && hit
    |=> skip == ($past(reg_q[io_addr][bit_sel]) ^ $past(op[0]))) else $error("skip");
  a_store_map: assert property (req && op == OP_DATA_STORE && hit && data_addr != IO_DATA_OFFSET
    |=> reg_q[$past(data_addr[5:0]) ^ 6'h20] == $past(wdata)) else $error("store");
  a_flag_keep: assert property (req && op == OP_IO_OUT && io_addr == 6'h00 && !wdata[7]
    |=> reg_q[0][7] == $past(reg_q[0][7] | flag_set[0])) else $error("keep");
  a_flag_clear: assert property (req && op == OP_IO_OUT && io_addr == 6'h00 && wdata[7] && !flag_set[0]
    |=> !reg_q[0][7]) else $error("clear");
  a_rmw_clear: assert property (req && op[2:1] == 2'b01 && io_addr == 6'h00 && !flag_set[0] &&
    !(op == OP_BIT_CLEAR && bit_sel == 3'h7) |=> !reg_q[0][7]) else $error("rmw");
  c_read: cover property (rvalid);
  c_skip: cover property (skip);
  c_flag: cover property (flag_set[0] ##1 reg_q[0][7]);
endmodule : io_space_checker
bind io_space_access_decode io_space_checker io_space_checker_i (.*);
`default_nettype wire

// ===== io_space_access_decode_tb.sv
// Bench for the decoder with a CPU model and a scoreboard.
// Assumes default parameters: one flag, bit 7 of location 0.
`timescale 1ns/1ps
`default_nettype none
module io_space_access_decode_tb;
  import io_space_pkg::*;
  logic clock = 1'b0, nrst = 1'b0, req, rvalid, skip, hit;
  io_op_e op;
  logic [5:0] io_addr;
  logic [15:0] data_addr;
  logic [2:0] bit_sel;
  logic [7:0] wdata, rdata, m [64], rq [$];
  logic [63:0] flag_set = '0;
  logic [63:0][7:0] reg_q;
  logic sq [$];
  int error_cnt = 0, checks = 0;
  io_cpu_model io_cpu_model_i (.*);
  io_space_access_decode io_space_access_decode_i (.*);
  initial forever #10 clock = ~clock;
  task cmp(input logic [7:0] g, e);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task cmp_skip(input logic g, e);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %0t skip got %b exp %b", $time, g, e);
    end
  endtask : cmp_skip
  always @(posedge clock)
  begin
    #2;
    if (rvalid === 1'b1) cmp(rdata, rq.pop_front());
    if (skip === 1'b1) cmp_skip(skip, sq.pop_front());
  end
  task run(input io_op_e o, input logic [15:0] a, input logic [2:0] b, input logic [7:0] d);
    logic [5:0] n;
    logic f;
    n = o[2:1] == 2'b11 ? a[5:0] ^ 6'h20 : a[5:0];
    f = m[0][7];
    io_cpu_model_i.go(o, a, b, d);
    case (o)
      OP_IO_IN, OP_DATA_LOAD: rq.push_back(m[n]);
      OP_IO_OUT, OP_DATA_STORE: m[n] = d;
      OP_BIT_SET, OP_BIT_CLEAR: m[n][b] = !o[0];
      default: if (m[n][b] ^ o[0]) sq.push_back(1'b1);
    endcase
    if (n == 6'h00 && o inside {OP_IO_OUT, OP_DATA_STORE, OP_BIT_SET, OP_BIT_CLEAR}) m[0][7] = f & !m[0][7];
  endtask : run
  task pulse();
    io_cpu_model_i.idle();
    flag_set[0] = 1'b1;
    m[0][7] = 1'b1;
    io_cpu_model_i.idle();
    flag_set[0] = 1'b0;
  endtask : pulse
  task tally_and_finish();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
    begin
      $display("ALL CHECKS OK");
    end
    else
    begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  initial
  begin
    void'($urandom(32'hc2d9));
    foreach (m[i]) m[i] = REG_RESET;
    repeat (2) @(posedge clock);
    #1 nrst = 1'b1;
    for (int i = 1; i < 64; i++) run(i[0] ? OP_IO_OUT : OP_DATA_STORE, 16'(i[0] ? i : i + 32), 3'h0, 8'($urandom));
    for (int i = 0; i < 8; i++)
    begin
      run(OP_SKIP_IF_SET, 16'h1f, 3'(i), 8'h00);
      run(OP_BIT_CLEAR, 16'h1f, 3'(i), 8'h00);
      run(OP_SKIP_IF_CLEAR, 16'h1f, 3'(i), 8'h00);
      run(OP_BIT_SET, 16'h1e, 3'(i), 8'h00);
    end
    io_cpu_model_i.go(OP_BIT_SET, 16'h20, 3'h0, 8'h00);
    io_cpu_model_i.go(OP_DATA_LOAD, 16'h60, 3'h0, 8'h00);
    pulse();
    run(OP_IO_OUT, 16'h00, 3'h0, 8'h00);
    run(OP_SKIP_IF_SET, 16'h00, 3'h7, 8'h00);
    run(OP_BIT_SET, 16'h00, 3'h0, 8'h00);
    run(OP_IO_IN, 16'h00, 3'h0, 8'h00);
    pulse();
    run(OP_IO_OUT, 16'h00, 3'h0, 8'h80);
    pulse();
    run(OP_BIT_CLEAR, 16'h00, 3'h7, 8'h00);
    for (int i = 0; i < 64; i++) run(i[1] ? OP_IO_IN : OP_DATA_LOAD, 16'(i[1] ? i : i + 32), 3'h0, 8'h00);
    io_cpu_model_i.idle();
    repeat (2) @(posedge clock);
    #3;
    cmp(8'(rq.size() + sq.size()), 8'h00);
    tally_and_finish();
  end
endmodule : io_space_access_decode_tb
`default_nettype wire
